// >>> rtl/cibae_pkg.sv
// Constants and carrier types for the cascaded interrupt bank controller.
// Assumes a single 25 MHz system clock shared by all users of the package.
package cibae_pkg;

  localparam int NBANK = 3;
  localparam int NLVL  = 8;
  localparam int EXT_N = 20;

  // Register bus request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cibae_req_t;

  // Host bus status lines, all active low.
  typedef struct packed {
    logic ads_n;
    logic m_io_n;
    logic d_c_n;
    logic w_r_n;
  } cibae_stat_t;

  // Address layout: bits 6:5 select the bank, bits 4:0 the register.
  localparam int         BANK_LSB      = 5;
  localparam logic [1:0] BANK_LAST     = 2'h2;
  localparam logic [1:0] VEC_PAGE      = 2'h0;
  localparam logic [4:0] OFF_MASK      = 5'h08;
  localparam logic [4:0] OFF_CASC      = 5'h09;
  localparam logic [4:0] OFF_INIT2     = 5'h0A;
  localparam logic [4:0] OFF_CMD       = 5'h0B;
  localparam logic [4:0] OFF_MODE      = 5'h0C;
  localparam logic [4:0] OFF_ISR       = 5'h0D;
  localparam logic [4:0] OFF_IRR       = 5'h0E;
  localparam logic [7:0] ADDR_INIT_VEC = 8'h60;

  // Command register: bits 7:6 code, bits 2:0 level.
  localparam int         CMD_LSB       = 6;
  localparam logic [1:0] CMD_NONSPEC   = 2'h1;
  localparam logic [1:0] CMD_SPEC      = 2'h2;
  localparam int         MODE_AUTO_END_OF_SERVICE_BIT = 0;

  localparam logic [7:0] VEC_RST       = 8'h00;
  localparam logic [7:0] IMR_RST       = 8'h00;
  localparam logic [7:0] NO_SLAVE_DATA = 8'h00;
  localparam logic [7:0] ONE_HOT_LSB   = 8'h01;

  localparam logic [2:0] LVL_CASC_A    = 3'h2;
  localparam logic [2:0] LVL_CASC_B    = 3'h0;
  localparam logic [2:0] LVL_DEFAULT   = 3'h7;

  localparam int CLK_PERIOD_NS = 40;
  localparam int ACK_WAIT_NS   = 80;
  localparam int ACK_WAIT_RAW  = (ACK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ACK_WAIT_CYC = 4'((ACK_WAIT_RAW < 1) ? 1 : ACK_WAIT_RAW);
  localparam logic [3:0] WCNT_ONE     = 4'h1;

endpackage

// >>> rtl/cibae_top.sv
// Three cascaded eight-level interrupt banks with two-cycle acknowledge.
// Assumes bus status pins and external requests are asynchronous to mclk,
// and that DMA request levels come from logic on mclk.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps

// Functional notes
// [RULE1] Writing a bank's second init word raises the init-word-written request.
// [RULE2] Reading the second init word back clears that request.
// [RULE3] Init request sits at first-bank level 1.5, ORed with and above the cascade.
// [RULE4] DMA chain and terminal-count levels request the first bank directly.
// [RULE5] With nothing pending, the default vector is first-bank level 7's vector.
// [RULE6] Host interrupt goes high when any unmasked request, cascaded or not, pends; the code ignores requests that an in-service bit inhibits.
// [RULE7] Acknowledge cycles are decoded from memory-io, data-control, write-read all low.
// [RULE8] First acknowledge resolves the winner and drives 00H when it has no slave.
// [RULE9] Second acknowledge drives the winner's vector for a non-cascaded input.
// [RULE10] For a slave input the vector register is driven as slave address first.
// [RULE11] Second acknowledge floats the data bus when the input has a slave.
// [RULE12] External requests must stay asserted until the first acknowledge begins.
// [RULE13] The host leaves four idle states between the two acknowledge cycles.
// [RULE14] Each acknowledge cycle gets automatic wait states for internal delay.
// [RULE15] Software sends end-of-service to each bank on the path and any slave.
// [RULE16] Non-specific end-of-service clears the highest-priority in-service bit.
// [RULE17] Software avoids non-specific end-of-service with set-priority or special mask.
// [RULE18] Specific end-of-service clears exactly the named in-service bit.
// [RULE19] Auto mode does a non-specific end-of-service when the second acknowledge ends.
// [RULE20] In auto mode the host keeps interrupts disabled during service.
// [RULE21] Fully nested priority: level 0 highest, level 7 lowest.
// [RULE22] Acknowledge sets the winner's in-service bit until end-of-service clears it.
// [RULE23] Each bank has an 8-bit mask, each set bit disabling one level.
// [RULE24] An in-service bit inhibits same and lower levels; higher ones still request.
// [RULE25] External requests are active low.
// [RULE26] Third bank feeds the second, the second feeds the first.
module cibae_top (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire cibae_pkg::cibae_req_t         sw_req,
  output logic [7:0]                         sw_rdata,
  input  wire cibae_pkg::cibae_stat_t        bus_stat,
  input  wire logic [cibae_pkg::EXT_N-1:0]   ext_req_n,
  input  wire logic                          dma_chain_request,
  input  wire logic                          dma_terminal_count_request,
  output logic                               host_interrupt_input,
  output logic [7:0]                         data_out,
  output logic                               data_oe,
  output logic                               ready_n
);
  import cibae_pkg::*;

  typedef enum logic {ST_FIRST, ST_SECOND} cibae_phase_t;

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = LVL_DEFAULT;
    for (int i = NLVL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  logic [EXT_N-1:0] ext_s1_q, ext_s2_q;
  cibae_stat_t      st_s1_q, st_s2_q;
  logic             ads_prev_q;
  logic [7:0]       vec_q [NBANK][NLVL];
  logic [7:0]       imr_q [NBANK];
  logic [7:0]       casc_q [NBANK];
  logic [7:0]       init2_q [NBANK];
  logic [7:0]       isr_q [NBANK];
  logic [NBANK-1:0] auto_end_of_service_q;
  logic [7:0]       init_vec_q;
  logic             init_req_q;
  cibae_phase_t     phase_q;
  logic             cyc2_q, slave_q, dflt_q;
  logic [7:0]       hold_vec_q, data_q, rdata_q;
  logic             data_oe_q, ready_n_q, host_int_q;
  logic [3:0]       wcnt_q;

  // Pins are unrelated to mclk, so only the second stage is looked at.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_s1_q   <= '1;
      ext_s2_q   <= '1;
      st_s1_q    <= '1;
      st_s2_q    <= '1;
      ads_prev_q <= 1'b1;
    end else begin
      ext_s1_q   <= ext_req_n;
      ext_s2_q   <= ext_s1_q;
      st_s1_q    <= bus_stat;
      st_s2_q    <= st_s1_q;
      ads_prev_q <= st_s2_q.ads_n;
    end
  end

  wire [EXT_N-1:0] ext_act = ~ext_s2_q; // RULE25
  wire ack_hit = ads_prev_q & ~st_s2_q.ads_n & ~st_s2_q.m_io_n
               & ~st_s2_q.d_c_n & ~st_s2_q.w_r_n; // RULE7
  wire ack_go   = ack_hit && (wcnt_q == 4'h0);
  wire ack1     = ack_go && (phase_q == ST_FIRST);
  wire ack2     = ack_go && (phase_q == ST_SECOND);
  wire ack_end  = (wcnt_q == WCNT_ONE);
  wire ack_end2 = ack_end && cyc2_q;

  // Software register decode.
  wire [1:0] rb      = sw_req.addr[BANK_LSB +: 2];
  wire [4:0] ro      = sw_req.addr[4:0];
  wire       in_bank = (rb <= BANK_LAST) && !sw_req.addr[7];
  wire [1:0] rbi     = in_bank ? rb : 2'h0;
  wire       wr_b    = sw_req.wr && in_bank;
  wire       wr_init2 = wr_b && (ro == OFF_INIT2);
  wire       rd_init2 = sw_req.rd && in_bank && (ro == OFF_INIT2);
  wire       cmd_wr  = wr_b && (ro == OFF_CMD);
  wire [1:0] cmd     = sw_req.wdata[CMD_LSB +: 2];

  // Request matrix and per-bank resolution.
  logic [7:0] pending_request_bits [NBANK];
  logic [7:0] elig [NBANK];
  logic [7:0] isr_low [NBANK];
  logic [2:0] win [NBANK];
  logic [NBANK-1:0] win_ok;
  wire casc_req_a = win_ok[1] | init_req_q; // RULE3

  assign pending_request_bits[0] = {ext_act[4:2], dma_terminal_count_request, ext_act[1],
                   casc_req_a, dma_chain_request, ext_act[0]}; // RULE4
  assign pending_request_bits[1] = {ext_act[11:5], win_ok[2]}; // RULE26
  assign pending_request_bits[2] = ext_act[19:12];

  for (genvar b = 0; b < NBANK; b++) begin : g_res
    wire [7:0] pend = pending_request_bits[b] & ~imr_q[b]; // RULE23
    assign isr_low[b] = isr_q[b] & (~isr_q[b] + ONE_HOT_LSB);
    assign elig[b]    = pend & (isr_low[b] - ONE_HOT_LSB); // RULE24
    assign win_ok[b]  = |elig[b];
    assign win[b]     = first_set(elig[b]); // RULE21
  end

  wire casc_a   = win_ok[0] && (win[0] == LVL_CASC_A) && !init_req_q; // RULE3
  wire casc_b   = casc_a && win_ok[1] && (win[1] == LVL_CASC_B);
  wire hit      = win_ok[0] && (!casc_a || win_ok[1]) && (!casc_b || win_ok[2]);
  wire [1:0] sel_b = casc_b ? 2'h2 : (casc_a ? 2'h1 : 2'h0);
  wire [2:0] sel_l = hit ? win[sel_b] : LVL_DEFAULT;
  wire use_init = hit && !casc_a && (win[0] == LVL_CASC_A);
  wire slave    = hit && !use_init && casc_q[sel_b][sel_l];
  wire [7:0] sel_vec = use_init ? init_vec_q
                     : (hit ? vec_q[sel_b][sel_l] : vec_q[0][LVL_DEFAULT]); // RULE5
  wire [NBANK-1:0] path = {casc_b, casc_a, 1'b1};

  // End-of-service and acknowledge effects on the in-service bits.
  logic [7:0] isr_set [NBANK];
  logic [7:0] isr_clr [NBANK];
  for (genvar b = 0; b < NBANK; b++) begin : g_isr
    wire eoi_ns = cmd_wr && (rb == 2'(b)) && (cmd == CMD_NONSPEC);
    wire eoi_sp = cmd_wr && (rb == 2'(b)) && (cmd == CMD_SPEC);
    wire auto_e = ack_end2 && auto_end_of_service_q[b]; // RULE19
    assign isr_set[b] = (ack1 && hit && path[b]) ? (ONE_HOT_LSB << win[b]) : 8'h00; // RULE22
    assign isr_clr[b] = (eoi_ns || auto_e) ? isr_low[b] // RULE16
                      : (eoi_sp ? (ONE_HOT_LSB << sw_req.wdata[2:0]) : 8'h00); // RULE18
  end

  // Read data mux; unmapped addresses read zero.
  wire [7:0] bank_rd =
      (ro[4:3] == VEC_PAGE) ? vec_q[rbi][ro[2:0]]
    : (ro == OFF_MASK)      ? imr_q[rbi]
    : (ro == OFF_CASC)      ? casc_q[rbi]
    : (ro == OFF_INIT2)     ? init2_q[rbi]
    : (ro == OFF_MODE)      ? {7'h00, auto_end_of_service_q[rbi]}
    : (ro == OFF_ISR)       ? isr_q[rbi]
    : (ro == OFF_IRR)       ? pending_request_bits[rbi]
    : 8'h00;
  wire [7:0] rd_val = in_bank ? bank_rd
                    : ((sw_req.addr == ADDR_INIT_VEC) ? init_vec_q : 8'h00);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NBANK; b++) begin
        for (int l = 0; l < NLVL; l++) begin
          vec_q[b][l] <= VEC_RST;
        end
        imr_q[b]   <= IMR_RST;
        casc_q[b]  <= 8'h00;
        init2_q[b] <= VEC_RST;
        isr_q[b]   <= 8'h00;
      end
      auto_end_of_service_q     <= '0;
      init_vec_q <= VEC_RST;
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        // The set term comes last so a same-cycle acknowledge is not lost.
        isr_q[b] <= (isr_q[b] & ~isr_clr[b]) | isr_set[b];
        if (wr_b && (rb == 2'(b))) begin
          if (ro[4:3] == VEC_PAGE) begin
            vec_q[b][ro[2:0]] <= sw_req.wdata;
          end
          if (ro == OFF_MASK) begin
            imr_q[b] <= sw_req.wdata;
          end
          if (ro == OFF_CASC) begin
            casc_q[b] <= sw_req.wdata;
          end
          if (ro == OFF_INIT2) begin
            init2_q[b] <= sw_req.wdata;
          end
          if (ro == OFF_MODE) begin
            auto_end_of_service_q[b] <= sw_req.wdata[MODE_AUTO_END_OF_SERVICE_BIT];
          end
        end
      end
      if (sw_req.wr && (sw_req.addr == ADDR_INIT_VEC)) begin
        init_vec_q <= sw_req.wdata;
      end
    end
  end

  // Init-word request; a write in the same cycle as the read-back wins.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_req_q <= 1'b0;
      rdata_q    <= 8'h00;
      host_int_q <= 1'b0;
    end else begin
      init_req_q <= wr_init2 | (init_req_q & ~rd_init2); // RULE1 RULE2
      rdata_q    <= sw_req.rd ? rd_val : 8'h00;
      host_int_q <= win_ok[0]; // RULE6
    end
  end

  // Acknowledge sequencer. Wait states come from the counter, and the data
  // stay on the bus until ready has been shown for one cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q    <= ST_FIRST;
      cyc2_q     <= 1'b0;
      slave_q    <= 1'b0;
      dflt_q     <= 1'b0;
      hold_vec_q <= 8'h00;
      data_q     <= 8'h00;
      data_oe_q  <= 1'b0;
      ready_n_q  <= 1'b1;
      wcnt_q     <= 4'h0;
    end else begin
      ready_n_q <= !ack_end; // RULE14
      if (ack_go) begin
        wcnt_q <= ACK_WAIT_CYC; // RULE14
      end else if (wcnt_q != 4'h0) begin
        wcnt_q <= wcnt_q - WCNT_ONE;
      end
      if (!ready_n_q) begin
        data_oe_q <= 1'b0;
      end
      if (ack1) begin
        phase_q    <= ST_SECOND;
        cyc2_q     <= 1'b0;
        slave_q    <= slave;
        dflt_q     <= !hit;
        hold_vec_q <= sel_vec;
        data_q     <= slave ? sel_vec : NO_SLAVE_DATA; // RULE8 RULE10
        data_oe_q  <= 1'b1;
      end else if (ack2) begin
        phase_q   <= ST_FIRST;
        cyc2_q    <= 1'b1;
        data_q    <= hold_vec_q; // RULE9
        data_oe_q <= !slave_q; // RULE11
      end
    end
  end

  assign sw_rdata             = rdata_q;
  assign host_interrupt_input = host_int_q;
  assign data_out             = data_q;
  assign data_oe              = data_oe_q;
  assign ready_n              = ready_n_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_init_set: assert property (wr_init2 |=> init_req_q) // RULE1
    else $error("init request not raised by init word write");
  chk_init_clr: assert property (rd_init2 && !wr_init2 |=> !init_req_q) // RULE2
    else $error("init request not cleared by read back");
  chk_host_int: assert property (win_ok[0] |=> host_interrupt_input) // RULE6
    else $error("host interrupt missing with request pending");
  chk_first_zero: assert property (ack1 && !slave |=> data_oe && data_out == 8'h00) // RULE8
    else $error("first acknowledge did not drive zero");
  chk_slave_addr: assert property (ack1 && slave |=> data_out == $past(sel_vec)) // RULE10
    else $error("slave address not driven");
  chk_slave_float: assert property (ack2 && slave_q |=> !data_oe) // RULE11
    else $error("bus not floated for slave vector");
  chk_wait_len: assert property (ack_go |=> ready_n ##[1:16] !ready_n) // RULE14
    else $error("acknowledge wait never ended");
  chk_isr_set: assert property (ack1 && hit |=> isr_q[0][$past(win[0])]) // RULE22
    else $error("in-service bit not set on acknowledge");
  chk_default_vec: assert property (ack2 && dflt_q |=> data_out == vec_q[0][LVL_DEFAULT]) // RULE5
    else $error("default vector wrong");
  chk_nonspec: assert property (cmd_wr && rb == 2'h0 && cmd == CMD_NONSPEC && !ack1 // RULE16
                                |=> (isr_q[0] & $past(isr_low[0])) == 8'h00)
    else $error("non-specific end-of-service left top bit set");
  chk_spec_eoi: assert property (cmd_wr && rb == 2'h0 && cmd == CMD_SPEC && !ack1 // RULE18
                                 |=> !isr_q[0][$past(sw_req.wdata[2:0])])
    else $error("specific end-of-service left named bit set");
  chk_auto_eoi: assert property (ack_end2 && auto_end_of_service_q[2] // RULE19
                                 |=> (isr_q[2] & $past(isr_low[2])) == 8'h00)
    else $error("auto end-of-service left top bit set");
  chk_second_vec: assert property (ack2 && !slave_q // RULE9
                                   |=> data_oe && data_out == $past(hold_vec_q))
    else $error("second acknowledge did not drive the vector");

endmodule

// >>> verification/cibae_host_model.sv
// Host processor model that runs the two-cycle interrupt acknowledge sequence.
// Assumes ready_n, data_out and data_oe come from the block on mclk.
`timescale 1ns/100ps
module cibae_host_model (
  input  wire logic              mclk,
  input  wire logic              ready_n,
  input  wire logic [7:0]        data_out,
  input  wire logic              data_oe,
  output cibae_pkg::cibae_stat_t bus_stat
);
  import cibae_pkg::*;

  // Status lines idle high, so no acknowledge can be decoded by accident.
  initial bus_stat = '1;

  // One acknowledge cycle; data is taken at the edge that sees ready low.
  // A missing ready leaves unknown values, which the bench then flags.
  task automatic ack_cycle(output logic [7:0] d, output logic oe);
    int n;
    n = 0;
    d = 'x;
    oe = 1'bx;
    bus_stat <= '0;
    do begin
      @(posedge mclk);
      n++;
    end while (ready_n !== 1'b0 && n < 40);
    if (ready_n === 1'b0) begin
      d = data_out;
      oe = data_oe;
    end
    bus_stat <= '1;
  endtask

  // Acknowledges only when the bench asks, as a host with interrupts disabled would.
  task automatic ack_pair(output logic [7:0] d1, output logic oe1,
                          output logic [7:0] d2, output logic oe2);
    ack_cycle(d1, oe1);
    repeat (4) @(posedge mclk);
    ack_cycle(d2, oe2);
  endtask
endmodule

// >>> verification/cibae_top_tb_top.sv
// Testbench for the cascaded interrupt banks: registers, acknowledge, end-of-service.
// Assumes the host model answers acknowledge cycles when this bench asks.
`timescale 1ns/100ps
module cibae_top_tb_top;
  import cibae_pkg::*;
  logic             mclk;
  logic             rst;
  cibae_req_t       sw_req;
  logic [7:0]       sw_rdata;
  cibae_stat_t      bus_stat;
  logic [EXT_N-1:0] ext_req_n;
  logic             dma_chain_request;
  logic             dma_terminal_count_request;
  logic             host_interrupt_input;
  logic [7:0]       data_out;
  logic             data_oe;
  logic             ready_n;
  logic [7:0]       d1;
  logic [7:0]       d2;
  logic             oe1;
  logic             oe2;
  int               mismatches;
  int               compares;

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  cibae_top i_dut (.mclk(mclk), .rst(rst), .sw_req(sw_req), .sw_rdata(sw_rdata),
    .bus_stat(bus_stat), .ext_req_n(ext_req_n), .dma_chain_request(dma_chain_request),
    .dma_terminal_count_request(dma_terminal_count_request),
    .host_interrupt_input(host_interrupt_input), .data_out(data_out),
    .data_oe(data_oe), .ready_n(ready_n));
  cibae_host_model i_host (.mclk(mclk), .ready_n(ready_n), .data_out(data_out),
    .data_oe(data_oe), .bus_stat(bus_stat));

  function automatic logic [7:0] ra(input logic [1:0] b, input logic [4:0] o);
    return {1'b0, b, o};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes are dropped after one cycle and an idle cycle follows each access.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sw_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    sw_req <= '0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    sw_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    sw_req <= '0;
    @(posedge mclk);
    chk(what, exp, sw_rdata);
  endtask

  // Pins pass a two-stage synchroniser, so the flag is looked at a few cycles later.
  task automatic int_chk(input logic exp);
    repeat (6) @(posedge mclk);
    chk("host_interrupt_input", {7'h00, exp}, {7'h00, host_interrupt_input});
  endtask

  task automatic ack_chk(input logic [7:0] e1, input logic [7:0] e2, input logic o2);
    i_host.ack_pair(d1, oe1, d2, oe2);
    chk("ack1 data", e1, d1);
    chk("ack1 oe", 8'h01, {7'h00, oe1});
    if (o2) chk("ack2 data", e2, d2);
    chk("ack2 oe", {7'h00, o2}, {7'h00, oe2});
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    sw_req = '0;
    ext_req_n = '1;
    dma_chain_request = 1'b0;
    dma_terminal_count_request = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("ready_n", 8'h01, {7'h00, ready_n});
    rd_chk("mask0", ra(2'h0, OFF_MASK), IMR_RST);
    rd_chk("unmapped", 8'h7F, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ra(2'h0, 5'(i)), 8'h40 + 8'(i));
    end
    int_chk(1'b0);
    ack_chk(NO_SLAVE_DATA, 8'h47, 1'b1);
    rd_chk("isr0", ra(2'h0, OFF_ISR), 8'h00);
    ext_req_n[2] <= 1'b0;
    dma_terminal_count_request <= 1'b1;
    int_chk(1'b1);
    ack_chk(8'h00, 8'h44, 1'b1);
    rd_chk("isr0", ra(2'h0, OFF_ISR), 8'h10);
    int_chk(1'b0);
    ext_req_n[0] <= 1'b0;
    int_chk(1'b1);
    ack_chk(8'h00, 8'h40, 1'b1);
    wr(ra(2'h0, OFF_CMD), {CMD_NONSPEC, 6'h00});
    rd_chk("isr0", ra(2'h0, OFF_ISR), 8'h10);
    ext_req_n[0] <= 1'b1;
    dma_terminal_count_request <= 1'b0;
    wr(ra(2'h0, OFF_CMD), {CMD_SPEC, 3'h0, 3'h4});
    rd_chk("isr0", ra(2'h0, OFF_ISR), 8'h00);
    wr(ra(2'h0, OFF_MASK), 8'h20);
    int_chk(1'b0);
    wr(ra(2'h0, OFF_MASK), 8'h00);
    ack_chk(8'h00, 8'h45, 1'b1);
    ext_req_n[2] <= 1'b1;
    wr(ra(2'h0, OFF_CMD), {CMD_SPEC, 3'h0, 3'h5});
    wr(ADDR_INIT_VEC, 8'h66);
    wr(ra(2'h1, 5'h01), 8'h51);
    ext_req_n[5] <= 1'b0;
    wr(ra(2'h1, OFF_INIT2), 8'h99);
    ack_chk(8'h00, 8'h66, 1'b1);
    rd_chk("init2", ra(2'h1, OFF_INIT2), 8'h99);
    wr(ra(2'h0, OFF_CMD), {CMD_NONSPEC, 6'h00});
    ack_chk(8'h00, 8'h51, 1'b1);
    rd_chk("isr1", ra(2'h1, OFF_ISR), 8'h02);
    ext_req_n[5] <= 1'b1;
    wr(ra(2'h1, OFF_CMD), {CMD_NONSPEC, 6'h00});
    wr(ra(2'h0, OFF_CMD), {CMD_NONSPEC, 6'h00});
    wr(ra(2'h2, OFF_MODE), 8'h01);
    wr(ra(2'h2, 5'h00), 8'h30);
    ext_req_n[12] <= 1'b0;
    int_chk(1'b1);
    ack_chk(8'h00, 8'h30, 1'b1);
    rd_chk("isr2", ra(2'h2, OFF_ISR), 8'h00);
    rd_chk("isr1", ra(2'h1, OFF_ISR), 8'h01);
    ext_req_n[12] <= 1'b1;
    wr(ra(2'h1, OFF_CMD), {CMD_NONSPEC, 6'h00});
    wr(ra(2'h0, OFF_CMD), {CMD_NONSPEC, 6'h00});
    wr(ra(2'h0, OFF_CASC), 8'h08);
    wr(ra(2'h0, 5'h03), 8'h5A);
    ext_req_n[1] <= 1'b0;
    int_chk(1'b1);
    ack_chk(8'h5A, 8'h00, 1'b0);
    ext_req_n[1] <= 1'b1;
    wr(ra(2'h0, OFF_CMD), {CMD_NONSPEC, 6'h00});
    dma_chain_request <= 1'b1;
    int_chk(1'b1);
    ack_chk(8'h00, 8'h41, 1'b1);
    rd_chk("isr0", ra(2'h0, OFF_ISR), 8'h02);
    print_verdict();
  end
endmodule
